//--- src/uhpm_consts.vh
// constants for the uart host port and modem line block
`ifndef UHPM_CONSTS_VH
`define UHPM_CONSTS_VH

// =====================================================
// register offsets on the three select bits
`define UHPM_OFF_IER 3'h1
`define UHPM_OFF_AFR 3'h2
`define UHPM_OFF_MCTL 3'h4
`define UHPM_OFF_MSR 3'h6
`define UHPM_OFF_SCR 3'h7

// =====================================================
// field positions
`define UHPM_IER_MSI 3
`define UHPM_AFR_RS485 4
`define UHPM_MCTL_DTR 0
`define UHPM_MCTL_LOOP 4
`define UHPM_MCTL_AUTOCTS 5
`define UHPM_MSR_DCTS 0
`define UHPM_MSR_DDSR 1
`define UHPM_MSR_DDCD 3
`define UHPM_MSR_CTS 4
`define UHPM_MSR_DSR 5
`define UHPM_MSR_DCD 7

// =====================================================
// reset values and the read value of unmapped offsets
`define UHPM_RST_REG 8'h00
`define UHPM_RST_SYNC 3'h7
`define UHPM_READ_NONE 8'h00

`endif

//--- src/uhpm_sync.v
// two-stage synchroniser for the modem status inputs
`timescale 1ns/1ps
`default_nettype none
module uhpm_sync #(
  parameter WIDTH = 3
) (
  input wire sys_clk, // system clock
  input wire rstn, // synchronous reset, active low
  input wire [WIDTH-1:0] asyncIn, // raw pin levels
  input wire [WIDTH-1:0] resetVal, // level taken during reset
  output wire [WIDTH-1:0] syncOut // synchronised levels
);
  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;
  genvar i;

  // =====================================================
  // per-bit double flop; the first stage feeds only the second
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      always @(posedge sys_clk) begin
        if (!rstn) begin
          stage1_q[i] <= resetVal[i];
          stage2_q[i] <= resetVal[i];
        end else begin
          stage1_q[i] <= asyncIn[i];
          stage2_q[i] <= stage1_q[i];
        end
      end
    end
  endgenerate

  assign syncOut = stage2_q;
endmodule
`default_nettype wire

//--- src/uhpm_top.v
// host parallel port and modem handshake lines of one serial element
`timescale 1ns/1ps
`default_nettype none
`include "uhpm_consts.vh"
module uhpm_top (
  input wire sys_clk, // system clock, 50 MHz
  input wire rstn, // synchronous master reset, active low
  input wire chipSelN, // chip select, active low
  input wire read_strobe_n, // read strobe, active low
  input wire write_strobe_n, // write strobe, active low
  input wire reg_sel_bit0, // register select bit 0
  input wire reg_sel_bit1, // register select bit 1
  input wire reg_sel_bit2, // register select bit 2
  input wire ifaceSel, // high: separate strobes, low: write strobe only
  input wire [7:0] dataIn, // data bus as seen from the pins
  output reg [7:0] dataOut, // data bus driven value
  output reg dataOe, // high while the bus is driven
  input wire ctsN, // clear to send, active low
  input wire dsrN, // data set ready, active low
  input wire cdN, // carrier detect, active low
  input wire txPending, // transmitter holds data still to send
  output reg txAllowed, // transmitter may proceed
  output reg dtrN, // data terminal ready, active low
  output reg modemIrq // modem status interrupt, active high
);
  // one-hot access states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_READ = 3'b010;
  localparam [2:0] ST_HOLD = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] selLatch_q;
  reg csPrev_q;
  reg [7:0] intEnable_q;
  reg [7:0] altFunc_q;
  reg [7:0] modem_control_reg_q;
  reg [7:0] scratch_q;
  reg [2:0] linePrev_q;
  reg [2:0] delta_q;
  reg [2:0] delta_d;
  reg [2:0] irqPend_q;
  reg [2:0] irqPend_d;
  wire [2:0] regSel;
  wire [2:0] lineSync;
  wire [2:0] lineChange;
  wire csActive;
  wire csFall;
  reg wrNow;
  reg rdStart;
  reg rdEnd;
  reg [7:0] rdMux;
  wire msrClear;
  wire ctsActive;
  wire dsrActive;
  wire cdActive;
  wire loopMode;
  wire autoCts;
  wire rs485Mode;
  wire irqLevel;

  // =====================================================
  // decode helpers

  // true when the select bits point at a given register
  function hitReg;
    input [2:0] sel;
    input [2:0] offset;
    begin
      hitReg = (sel == offset);
    end
  endfunction

  assign regSel = {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0};
  assign csActive = !chipSelN;
  assign csFall = csActive && csPrev_q; // csPrev_q holds last chip select high level

  // =====================================================
  // modem line synchronisers; idle level is high (inactive)
  uhpm_sync #(
    .WIDTH(3)
  ) uSync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .asyncIn({cdN, dsrN, ctsN}),
    .resetVal(`UHPM_RST_SYNC),
    .syncOut(lineSync)
  );

  assign ctsActive = !lineSync[0];
  assign dsrActive = !lineSync[1];
  assign cdActive = !lineSync[2]; // low on the pin means carrier found
  assign lineChange = lineSync ^ linePrev_q; // only synchronised levels compared

  assign loopMode = modem_control_reg_q[`UHPM_MCTL_LOOP];
  assign autoCts = modem_control_reg_q[`UHPM_MCTL_AUTOCTS];
  assign rs485Mode = altFunc_q[`UHPM_AFR_RS485];

  // =====================================================
  // access sequencing

  // decide start of read or write from the strobes and the interface select
  always @* begin
    state_d = state_q;
    wrNow = 1'b0;
    rdStart = 1'b0;
    rdEnd = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (csActive) begin
          if (ifaceSel) begin
            if (!read_strobe_n) begin
              rdStart = 1'b1;
              state_d = ST_READ;
            end else if (!write_strobe_n) begin
              wrNow = 1'b1;
              state_d = ST_HOLD;
            end
          end else if (csFall) begin
            // read strobe ignored here; write level at chip select fall picks direction
            if (!write_strobe_n) begin
              wrNow = 1'b1;
              state_d = ST_HOLD;
            end else begin
              rdStart = 1'b1;
              state_d = ST_READ;
            end
          end
        end
      end
      ST_READ: begin
        if (chipSelN || (ifaceSel && read_strobe_n)) begin
          rdEnd = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_HOLD: begin
        // one store per strobe; wait for release so a long strobe writes once
        if (chipSelN || (ifaceSel && write_strobe_n)) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // state, chip select history and latched select
  always @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      csPrev_q <= 1'b1;
      selLatch_q <= 3'h0;
    end else begin
      state_q <= state_d;
      csPrev_q <= chipSelN;
      if (rdStart) begin
        selLatch_q <= regSel;
      end
    end
  end

  // =====================================================
  // writable registers

  // bus bit n lands in register bit n, so bit 0 stays the lsb
  // writes to the status offset or unmapped offsets fall through and change nothing
  always @(posedge sys_clk) begin
    if (!rstn) begin
      intEnable_q <= `UHPM_RST_REG;
      altFunc_q <= `UHPM_RST_REG;
      modem_control_reg_q <= `UHPM_RST_REG;
      scratch_q <= `UHPM_RST_REG;
    end else if (wrNow) begin
      if (hitReg(regSel, `UHPM_OFF_IER)) begin
        intEnable_q <= dataIn;
      end
      if (hitReg(regSel, `UHPM_OFF_AFR)) begin
        altFunc_q <= dataIn;
      end
      if (hitReg(regSel, `UHPM_OFF_MCTL)) begin
        modem_control_reg_q <= dataIn;
      end
      if (hitReg(regSel, `UHPM_OFF_SCR)) begin
        scratch_q <= dataIn;
      end
    end
  end

  // =====================================================
  // modem status change flags

  // flags clear when a status read ends; a change in that same cycle still sets
  assign msrClear = rdEnd && hitReg(selLatch_q, `UHPM_OFF_MSR);

  always @* begin
    delta_d = msrClear ? 3'h0 : delta_q;
    delta_d = delta_d | lineChange;
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      linePrev_q <= `UHPM_RST_SYNC;
      delta_q <= 3'h0;
      irqPend_q <= 3'h0;
    end else begin
      linePrev_q <= lineSync;
      delta_q <= delta_d;
      irqPend_q <= irqPend_d;
    end
  end

  // =====================================================
  // modem interrupt pending

  // a change counts only if its interrupt is allowed at the moment it happens,
  // so enabling later does not turn an old change into a fresh interrupt
  always @* begin
    irqPend_d = msrClear ? 3'h0 : irqPend_q;
    if (intEnable_q[`UHPM_IER_MSI]) begin
      irqPend_d[0] = irqPend_d[0] | (lineChange[0] & !autoCts);
      irqPend_d[2:1] = irqPend_d[2:1] | lineChange[2:1];
    end
  end

  // =====================================================
  // read path

  // register read mux; unmapped offsets read as zero
  // the status byte is rebuilt every cycle, so a long read shows live line levels
  always @* begin
    rdMux = `UHPM_READ_NONE;
    if (hitReg(selLatch_q, `UHPM_OFF_IER)) begin
      rdMux = intEnable_q;
    end else if (hitReg(selLatch_q, `UHPM_OFF_AFR)) begin
      rdMux = altFunc_q;
    end else if (hitReg(selLatch_q, `UHPM_OFF_MCTL)) begin
      rdMux = modem_control_reg_q;
    end else if (hitReg(selLatch_q, `UHPM_OFF_MSR)) begin
      rdMux[`UHPM_MSR_DCTS] = delta_q[0];
      rdMux[`UHPM_MSR_DDSR] = delta_q[1];
      rdMux[`UHPM_MSR_DDCD] = delta_q[2];
      rdMux[`UHPM_MSR_CTS] = ctsActive;
      rdMux[`UHPM_MSR_DSR] = dsrActive;
      rdMux[`UHPM_MSR_DCD] = cdActive;
    end else if (hitReg(selLatch_q, `UHPM_OFF_SCR)) begin
      rdMux = scratch_q;
    end
  end

  // bus drive flag; only in the read state, dropping the edge after a release is seen
  always @(posedge sys_clk) begin
    if (!rstn) begin
      dataOe <= 1'b0;
    end else begin
      dataOe <= (state_q == ST_READ) && (state_d == ST_READ);
    end
  end

  // bus data trails the read state by a cycle; zero outside reads so nothing stale leaks out
  always @(posedge sys_clk) begin
    if (!rstn) begin
      dataOut <= 8'h00;
    end else if (state_q == ST_READ) begin
      dataOut <= rdMux;
    end else begin
      dataOut <= 8'h00;
    end
  end

  // =====================================================
  // modem outputs and interrupt

  // interrupt pin follows any pending cause while the enable stays set
  assign irqLevel = intEnable_q[`UHPM_IER_MSI] && (|irqPend_q);

  // loop mode wins over everything so the line is quiet during self test
  always @(posedge sys_clk) begin
    if (!rstn) begin
      dtrN <= 1'b1;
    end else if (loopMode) begin
      dtrN <= 1'b1;
    end else if (rs485Mode) begin
      dtrN <= !txPending;
    end else begin
      dtrN <= !modem_control_reg_q[`UHPM_MCTL_DTR];
    end
  end

  // transmit gate and interrupt pin, both one edge behind their causes
  always @(posedge sys_clk) begin
    if (!rstn) begin
      txAllowed <= 1'b0;
      modemIrq <= 1'b0;
    end else begin
      txAllowed <= !autoCts || ctsActive;
      modemIrq <= irqLevel;
    end
  end
endmodule
`default_nettype wire

//--- bench/uhpm_top_asserts.sv
// checker for the host port and modem lines
`timescale 1ns/1ps
`default_nettype none
module uhpm_top_asserts (
  input wire logic sys_clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic chipSelN, // select
  input wire logic read_strobe_n, // read strobe
  input wire logic write_strobe_n, // write strobe
  input wire logic reg_sel_bit0, // select bit 0
  input wire logic reg_sel_bit1, // select bit 1
  input wire logic reg_sel_bit2, // select bit 2
  input wire logic ifaceSel, // strobe mode
  input wire logic [7:0] dataIn, // bus in
  input wire logic [7:0] dataOut, // bus out
  input wire logic dataOe, // bus drive
  input wire logic ctsN, // modem line
  input wire logic dsrN, // modem line
  input wire logic cdN, // modem line
  input wire logic txAllowed, // gate
  input wire logic dtrN, // ready out
  input wire logic modemIrq // interrupt
);
  // =====
  // helper ages
  logic [2:0] regSel;
  logic [3:0] pinAge;
  logic [3:0] evtAge;
  assign regSel = {reg_sel_bit2, reg_sel_bit1, reg_sel_bit0};
  // ages saturate, so an old edge can never excuse a new interrupt
  always @(posedge sys_clk) begin
    if (!rstn || $changed({ctsN, dsrN, cdN})) begin
      pinAge <= 4'h0;
      evtAge <= 4'h0;
    end else begin
      pinAge <= pinAge + {3'h0, pinAge != 4'hF};
      evtAge <= (!chipSelN && !write_strobe_n) ? 4'h0 : evtAge + {3'h0, evtAge != 4'hF};
    end
  end
  // =====
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  chk_oe_needs_cs: assert property (dataOe |-> !$past(chipSelN))
    else $error("bus driven while not selected");
  chk_read_answer: assert property ((ifaceSel && !chipSelN && !read_strobe_n)[*3] |-> dataOe)
    else $error("read not answered");
  chk_write_only: assert property (!ifaceSel && $fell(chipSelN) && write_strobe_n |-> ##2 dataOe)
    else $error("select fall did not read");
  chk_cts_level: assert property (dataOe && regSel == 3'h6 && pinAge > 4'h6 |-> dataOut[4] == !ctsN)
    else $error("clear to send level wrong");
  chk_dsr_level: assert property (dataOe && regSel == 3'h6 && pinAge > 4'h6 |-> dataOut[5] == !dsrN)
    else $error("data set ready level wrong");
  chk_irq_cause: assert property ($rose(modemIrq) |-> evtAge < 4'h8)
    else $error("interrupt without a cause");
  chk_tx_gate: assert property ((!ctsN)[*5] |-> txAllowed)
    else $error("transmitter held while cleared");
  chk_loop_dtr: assert property (ifaceSel && !chipSelN && !write_strobe_n
    && read_strobe_n && regSel == 3'h4 && dataIn[4] |-> ##2 dtrN[*2])
    else $error("ready active in loop mode");
  cover property (dataOe && regSel == 3'h6);
  cover property ($rose(modemIrq));
  cover property (!txAllowed);
endmodule
bind uhpm_top uhpm_top_asserts chk (.sys_clk, .rstn, .chipSelN, .read_strobe_n,
  .write_strobe_n, .reg_sel_bit0, .reg_sel_bit1, .reg_sel_bit2, .ifaceSel, .dataIn,
  .dataOut, .dataOe, .ctsN, .dsrN, .cdN, .txAllowed, .dtrN, .modemIrq);
`default_nettype wire

//--- bench/uhpm_modem_model.sv
// modem driving the handshake inputs
`timescale 1ns/1ps
`default_nettype none
module uhpm_modem_model (
  input wire logic sys_clk, // clock
  input wire logic slow, // answer three cycles late
  input wire logic [2:0] wantOn, // carrier, dsr, cts wanted on
  output wire logic ctsN, // clear to send
  output wire logic dsrN, // data set ready
  output wire logic cdN // carrier detect
);
  // =====
  // line levels
  logic [2:0] lvl = 3'h0;
  logic [8:0] dly = 9'h000;
  // a slow modem moves lines long after it was asked
  always @(posedge sys_clk) begin
    dly <= {dly[5:0], wantOn};
    lvl <= slow ? dly[8:6] : wantOn;
  end
  assign ctsN = !lvl[0]; // active low
  assign dsrN = !lvl[1]; // active low
  assign cdN = !lvl[2]; // low while a carrier is found
endmodule
`default_nettype wire

//--- bench/uhpm_top_bench.sv
// self-checking bench for the host port and modem lines
`timescale 1ns/1ps
`default_nettype none
module uhpm_top_bench;
  // =====
  // wiring
  logic sys_clk = 1'b0, rstn = 1'b0, csN = 1'b1, rdN = 1'b1, wrN = 1'b1, mode = 1'b1;
  logic txPend = 1'b0, hostEn = 1'b0, slow = 1'b0;
  logic [2:0] sel = 3'h0, want = 3'h0;
  logic [7:0] hostData = 8'h00, pat = 8'h5A, rnd;
  integer n_errors = 0, num_checks = 0, cycles = 0, seed = 80223, i;
  wire [7:0] dOut;
  wire oe, txOk, dtrN, irq, ctsN, dsrN, cdN;
  // an undriven bus shows a pattern that flips each cycle
  wire [7:0] bus = oe ? dOut : (hostEn ? hostData : pat);
  uhpm_top dut (.sys_clk(sys_clk), .rstn(rstn), .chipSelN(csN), .read_strobe_n(rdN),
    .write_strobe_n(wrN), .reg_sel_bit0(sel[0]), .reg_sel_bit1(sel[1]), .reg_sel_bit2(sel[2]),
    .ifaceSel(mode), .dataIn(bus), .dataOut(dOut), .dataOe(oe), .ctsN(ctsN), .dsrN(dsrN),
    .cdN(cdN), .txPending(txPend), .txAllowed(txOk), .dtrN(dtrN), .modemIrq(irq));
  uhpm_modem_model modem (.sys_clk(sys_clk), .slow(slow), .wantOn(want), .ctsN(ctsN),
    .dsrN(dsrN), .cdN(cdN));
  initial forever #10 sys_clk = ~sys_clk;
  // float pattern and hang guard
  always @(posedge sys_clk) begin
    pat <= ~pat;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      conclude;
    end
  end
  // =====
  // tasks
  task same(input [7:0] got, input [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    @(posedge sys_clk);
    csN <= 1'b0;
    wrN <= 1'b0;
    sel <= a;
    hostData <= d;
    hostEn <= 1'b1;
    @(posedge sys_clk);
    csN <= 1'b1;
    wrN <= 1'b1;
    hostEn <= 1'b0;
  endtask
  // read strobe stays high in write-strobe-only mode
  task rdChk(input [2:0] a, input [7:0] exp);
    integer w;
    @(posedge sys_clk);
    csN <= 1'b0;
    rdN <= !mode;
    sel <= a;
    for (w = 0; w < 8 && oe !== 1'b1; w = w + 1) @(posedge sys_clk);
    same(dOut, exp);
    csN <= 1'b1;
    rdN <= 1'b1;
    for (w = 0; w < 8 && oe !== 1'b0; w = w + 1) @(posedge sys_clk);
  endtask
  function [7:0] msr(input [2:0] on, input [2:0] chg);
    msr = {on[2], 1'b0, on[1], on[0], chg[2], 1'b0, chg[1], chg[0]};
  endfunction
  task conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // =====
  // main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    same({7'h0, dtrN}, 8'h01);
    for (i = 0; i < 6; i = i + 1) begin
      rnd = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      wr(3'h7, rnd);
      rdChk(3'h7, rnd);
    end
    @(posedge sys_clk);
    sel <= 3'h7;
    hostData <= ~rnd;
    hostEn <= 1'b1;
    wrN <= 1'b0;
    repeat (2) @(posedge sys_clk);
    wrN <= 1'b1;
    hostEn <= 1'b0;
    rdChk(3'h7, rnd);
    rdChk(3'h3, 8'h00);
    $display("register tests done");
    wr(3'h4, 8'h01);
    repeat (3) @(posedge sys_clk);
    same({7'h0, dtrN}, 8'h00);
    wr(3'h4, 8'h11);
    repeat (3) @(posedge sys_clk);
    same({7'h0, dtrN}, 8'h01);
    wr(3'h2, 8'h10);
    wr(3'h4, 8'h01);
    txPend <= 1'b1;
    repeat (3) @(posedge sys_clk);
    same({7'h0, dtrN}, 8'h00);
    txPend <= 1'b0;
    repeat (3) @(posedge sys_clk);
    same({7'h0, dtrN}, 8'h01);
    wr(3'h2, 8'h00);
    $display("ready line tests done");
    wr(3'h1, 8'h08);
    want <= 3'h1;
    repeat (8) @(posedge sys_clk);
    same({7'h0, irq}, 8'h01);
    rdChk(3'h6, msr(3'h1, 3'h1));
    rdChk(3'h6, msr(3'h1, 3'h0));
    same({7'h0, irq}, 8'h00);
    slow <= 1'b1;
    want <= 3'h3;
    repeat (12) @(posedge sys_clk);
    same({7'h0, irq}, 8'h01);
    rdChk(3'h6, msr(3'h3, 3'h2));
    want <= 3'h7;
    repeat (12) @(posedge sys_clk);
    rdChk(3'h6, msr(3'h7, 3'h4));
    slow <= 1'b0;
    wr(3'h4, 8'h20);
    want <= 3'h6;
    repeat (8) @(posedge sys_clk);
    same({7'h0, txOk}, 8'h00);
    same({7'h0, irq}, 8'h00);
    rdChk(3'h6, msr(3'h6, 3'h1));
    want <= 3'h7;
    repeat (8) @(posedge sys_clk);
    same({7'h0, txOk}, 8'h01);
    $display("modem tests done");
    mode <= 1'b0;
    wr(3'h7, 8'hA5);
    rdChk(3'h7, 8'hA5);
    $display("strobe mode tests done");
    conclude;
  end
endmodule
`default_nettype wire
